/* File: dv/pin_src_model.sv */
// External pin sources and free-running low-frequency tick
`timescale 1ns/10ps
module pin_src_model
    import pin_irq_pkg::*;
#(
    parameter int LF_PER = 8
)
(
    input wire logic clk_in,
    input wire logic srst_in,
    output logic [CHANNELS-1:0] pin_out,
    output logic lf_tick_out
);
    // ****************
    // Pins
    // ****************
    int lf_cnt;

    // Fixed-edge pins idle high, programmable ones idle low
    initial begin
        pin_out = 6'h21;
    end

    // Static task: never call two pulses at once
    task pulse(input int ch, input logic val, input int len);
        @(posedge clk_in);
        pin_out[ch] <= val;
        repeat (len) @(posedge clk_in);
        pin_out[ch] <= ~val;
    endtask

    // ****************
    // Low-frequency tick
    // ****************
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            lf_cnt <= 0;
        end else begin
            lf_cnt <= (lf_cnt == LF_PER - 1) ? 0 : lf_cnt + 1;
        end
    end
    assign lf_tick_out = (lf_cnt == LF_PER - 1);
endmodule

/* File: dv/tb.sv */
// Self-checking bench for the six-channel pin interrupt front end
`timescale 1ns/10ps
module tb;
    import pin_irq_pkg::*;
    localparam int LF_PER = 8;
    logic CLK_IN = 1'b0;
    logic SRST_IN = 1'b1;
    mode_t MODE_IN = MODE_FAST;
    logic [ADDR_W-1:0] ADDR_IN = 12'h000;
    logic [DATA_W-1:0] WDATA_IN = 8'h00;
    logic WR_IN = 1'b0;
    logic RD_IN = 1'b0;
    logic [CHANNELS-1:0] PIN_IN;
    logic LF_TICK_IN;
    logic [DATA_W-1:0] RDATA_OUT;
    logic [CHANNELS-1:0] IRQ_REQ_OUT;
    int error_cnt = 0;
    int comparisons = 0;
    int req_cnt [CHANNELS] = '{default: 0};
    int ival [4] = '{1, 4, 8, 16};
    int exp_cnt [4] = '{1, 1, 2, 0};
    logic exp_lvl [4] = '{1'b1, 1'b0, 1'b0, 1'b0};

    pin_irq_front i_pin_irq_front (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .PIN_IN(PIN_IN), .MODE_IN(MODE_IN),
        .LF_TICK_IN(LF_TICK_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
        .RDATA_OUT(RDATA_OUT), .IRQ_REQ_OUT(IRQ_REQ_OUT));
    pin_src_model #(.LF_PER(LF_PER)) i_pin_src_model (.clk_in(CLK_IN), .srst_in(SRST_IN), .pin_out(PIN_IN),
        .lf_tick_out(LF_TICK_IN));

    always #12.5 CLK_IN = ~CLK_IN;

    // Counting high cycles also catches requests wider than one cycle
    always @(posedge CLK_IN) begin
        for (int i = 0; i < CHANNELS; i++) begin
            if (IRQ_REQ_OUT[i] === 1'b1) req_cnt[i]++;
        end
    end

    // ****************
    // Helpers
    // ****************
    task compare_reg(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task compare_cnt(input string name, input int exp, input int got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %0d seen %0d", name, exp, got);
        end
    endtask
    task reg_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge CLK_IN);
        ADDR_IN <= a;
        WDATA_IN <= d;
        WR_IN <= 1'b1;
        @(posedge CLK_IN);
        WR_IN <= 1'b0;
    endtask
    task check_reg(input string name, input logic [11:0] a, input logic [7:0] exp);
        @(posedge CLK_IN);
        ADDR_IN <= a;
        RD_IN <= 1'b1;
        @(posedge CLK_IN);
        RD_IN <= 1'b0;
        #1;
        compare_reg(name, exp, RDATA_OUT);
    endtask
    task wait_cyc(input int n);
        repeat (n) @(posedge CLK_IN);
    endtask
    // Stands in for clearing the interrupt latch
    task clear_cnt();
        @(posedge CLK_IN);
        #1;
        foreach (req_cnt[i]) req_cnt[i] = 0;
    endtask
    task pulse_chk(input string name, input int ch, input logic val, input int len, input int exp);
        i_pin_src_model.pulse(ch, val, len);
        wait_cyc(4 * len + 20);
        compare_cnt(name, exp, req_cnt[ch]);
        clear_cnt();
    endtask

    // ****************
    // Scenarios
    // ****************
    task test_reset();
        check_reg("gate reset", GATE_ADDR, 8'h00);
        for (int i = 0; i < 4; i++) check_reg("ctrl reset", CTRL1_ADDR + 12'(i), 8'h00);
        check_reg("unmapped read", 12'hFDC, 8'h00);
        $display("test_reset done");
    endtask
    task test_gate();
        pulse_chk("ch0 gated off", 0, 1'b0, 4, 0);
        reg_wr(GATE_ADDR, 8'hFF);
        wait_cyc(20);
        clear_cnt();
        check_reg("gate", GATE_ADDR, 8'h3F);
        // Read data must fall back to idle one cycle later
        wait_cyc(1);
        #1;
        compare_reg("read data idle", 8'h00, RDATA_OUT);
        reg_wr(CTRL4_ADDR, 8'hE3);
        check_reg("ctrl4 top bits", CTRL4_ADDR, 8'h03);
        reg_wr(12'hFDC, 8'h55);
        check_reg("gate after unmapped write", GATE_ADDR, 8'h3F);
        pulse_chk("ch0 fall", 0, 1'b0, 2, 1);
        pulse_chk("ch5 fall", 5, 1'b0, 2, 1);
        reg_wr(GATE_ADDR, 8'h3E);
        wait_cyc(20);
        clear_cnt();
        pulse_chk("ch0 gate cleared", 0, 1'b0, 4, 0);
        reg_wr(GATE_ADDR, 8'h3F);
        wait_cyc(20);
        clear_cnt();
        pulse_chk("ch0 gate restored", 0, 1'b0, 4, 1);
        $display("test_gate done");
    endtask
    task test_triggers();
        for (int ch = 1; ch < 4; ch++) begin
            for (int c = 0; c < 4; c++) begin
                reg_wr(CTRL1_ADDR + 12'(ch - 1), {4'h0, 2'(c), 2'h0});
                wait_cyc(10);
                clear_cnt();
                pulse_chk("trigger count", ch, 1'b1, 10, exp_cnt[c]);
                check_reg("level bit", CTRL1_ADDR + 12'(ch - 1), {3'h0, exp_lvl[c], 2'(c), 2'h0});
            end
        end
        $display("test_triggers done");
    endtask
    task test_rates();
        for (int r = 0; r < 4; r++) begin
            reg_wr(CTRL4_ADDR, {6'h00, 2'(r)});
            wait_cyc(40);
            clear_cnt();
            pulse_chk("short pulse", 4, 1'b1, 2 * ival[r] - 1, 0);
            pulse_chk("long pulse", 4, 1'b1, 3 * ival[r] + 2, 1);
        end
        $display("test_rates done");
    endtask
    task test_level();
        reg_wr(CTRL4_ADDR, 8'h0C);
        wait_cyc(30);
        clear_cnt();
        wait_cyc(30);
        compare_cnt("level mode while low", 0, req_cnt[4]);
        i_pin_src_model.pulse(4, 1'b1, 40);
        wait_cyc(20);
        compare_cnt("level mode repeats", 1, int'(req_cnt[4] > 1));
        check_reg("level bit high", CTRL4_ADDR, 8'h1C);
        clear_cnt();
        pulse_chk("level mode stops", 4, 1'b1, 1, 0);
        reg_wr(CTRL4_ADDR, 8'h08);
        wait_cyc(10);
        clear_cnt();
        pulse_chk("ch4 both edges", 4, 1'b1, 10, 2);
        check_reg("ch4 level after fall", CTRL4_ADDR, 8'h08);
        $display("test_level done");
    endtask
    task test_halt();
        @(posedge CLK_IN);
        MODE_IN <= MODE_HALT;
        wait_cyc(10);
        clear_cnt();
        pulse_chk("ch0 halted", 0, 1'b0, 6, 0);
        @(posedge CLK_IN);
        MODE_IN <= MODE_FAST;
        wait_cyc(10);
        clear_cnt();
        pulse_chk("ch0 resumed", 0, 1'b0, 4, 1);
        $display("test_halt done");
    endtask
    task test_slow();
        reg_wr(CTRL1_ADDR, 8'h03);
        @(posedge CLK_IN);
        MODE_IN <= MODE_SLOW;
        wait_cyc(12 * LF_PER);
        clear_cnt();
        for (int ch = 0; ch < 2; ch++) begin
            pulse_chk("slow short", ch, ch == 1, 3 * LF_PER, 0);
            pulse_chk("slow long", ch, ch == 1, 9 * LF_PER, 1);
        end
        @(posedge CLK_IN);
        MODE_IN <= MODE_FAST;
        wait_cyc(2 + 3 * 16 + 10);
        clear_cnt();
        $display("test_slow done");
    endtask

    task tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge CLK_IN);
        SRST_IN <= 1'b0;
        @(posedge CLK_IN);
        test_reset();
        test_gate();
        test_triggers();
        test_rates();
        test_level();
        test_halt();
        test_slow();
        tally_and_finish();
    end

    // Whole run is a few thousand cycles
    initial begin
        repeat (60000) @(posedge CLK_IN);
        error_cnt++;
        tally_and_finish();
    end
endmodule

/* File: rtl/pin_irq_filter.sv */
// Sampling noise canceller for one interrupt pin
`timescale 1ns/10ps
module pin_irq_filter
    import pin_irq_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic run_in,
    input wire logic tick_in,
    input wire logic [1:0] need_in,
    input wire logic sample_in,
    output logic level_out
);

    logic last;
    logic [1:0] run_len;
    logic [2:0] next_len;

    assign next_len = {1'b0, run_len} + 3'h1;

    // Gated channel holds its state cleared, as if its clock were stopped
    always_ff @(posedge clk_in) begin
        if (srst_in || !run_in) begin
            last <= 1'b0;
            run_len <= 2'h0;
            level_out <= 1'b0;
        end else if (tick_in) begin
            last <= sample_in;
            if (sample_in == last && run_len != 2'h0) begin
                if (run_len != 2'h3) begin
                    run_len <= next_len[1:0];
                end
                if (next_len >= {1'b0, need_in}) begin
                    level_out <= sample_in;
                end
            end else begin
                run_len <= 2'h1;
            end
        end
    end

endmodule

/* File: rtl/pin_irq_front.sv */
// Six-channel pin interrupt front end: filters, detectors and registers
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps

// Operation
// - Channels 1-4 programmable trigger and rate; channels 0 and 5 fixed.
// - Channel 0 requests on each falling edge of its filtered level.
// - Channel 0 fast mode: under one gear period rejected, two accepted.
// - Fixed channels slow mode: under 4 slow periods rejected, 8 accepted.
// - Channels 1-3 trigger: 00 rise, 01 fall, 10 both, 11 reserved.
// - Channels 1-4 fast mode: gear-sampled pin resampled at the programmed interval.
// - Channels 1-4 fast mode: three agreeing samples accept a level, otherwise noise.
// - Rate code divides gear clock by 1,4,8,16; slow always slow clock/4.
// - Programmable fast: under two intervals rejected, over three plus one accepted.
// - Programmable slow: under 4 slow periods rejected, over 8 accepted.
// - Level bit reads 0 after reset or low, 1 if high at request.
// - Level bit reloads on every request to show which edge fired.
// - Channel 4 control bits 7 to 5 read as zero.
// - Clock gate bit 0 stops the channel; 1 restores it.
// - Clock gate bits reset to 0, all channels start disabled.
// - Channel 4 code 11 requests while the filtered level is high.
// - Slow mode: two agreeing samples at slow clock/4 accept a level.
// - Deep idle, deep sleep, stop: sampling halts, no requests raised.
// - Channel 5 requests on each falling edge, filtered like channel 0.
module pin_irq_front
    import pin_irq_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic SRST_IN,
    input wire logic [CHANNELS-1:0] PIN_IN,
    input wire mode_t MODE_IN,
    input wire logic LF_TICK_IN,
    input wire logic [ADDR_W-1:0] ADDR_IN,
    input wire logic [DATA_W-1:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [DATA_W-1:0] RDATA_OUT,
    output logic [CHANNELS-1:0] IRQ_REQ_OUT
);

    // ************************************************************
    // State
    // ************************************************************
    logic [CHANNELS-1:0] gate;
    logic [1:0] trig_sel [1:4];
    logic [1:0] rate_sel [1:4];
    logic lvl [1:4];
    logic [CHANNELS-1:0] pin_s;
    logic [CHANNELS-1:0] filt;
    logic [CHANNELS-1:0] filt_prev;
    logic [CHANNELS-1:0] next_req;
    logic [3:0] pre;
    logic [1:0] lf_div;
    logic lf_q4;
    logic [DATA_W-1:0] next_rdata;

    // ************************************************************
    // Sample clocks
    // ************************************************************
    // Pins are synchronous, so one register is the gear-clock sample
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            pin_s <= 6'h00;
        end else begin
            pin_s <= PIN_IN;
        end
    end

    // Shared prescaler; channels share phase, which saves counters
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            pre <= PRE_RESET;
        end else if (MODE_IN == MODE_FAST) begin
            pre <= pre + 4'h1;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            lf_div <= LF_DIV_RESET;
        end else if (MODE_IN == MODE_SLOW && LF_TICK_IN) begin
            lf_div <= lf_div + 2'h1;
        end
    end

    assign lf_q4 = (MODE_IN == MODE_SLOW) && LF_TICK_IN && (lf_div == LF_DIV_LAST);

    // ************************************************************
    // Channels
    // ************************************************************
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
        logic tick;
        logic [1:0] need;
        logic hit;

        if (ch == 0 || ch == CHANNELS - 1) begin : g_fixed
            // Every gear clock in fast mode, slow clock/4 in slow mode
            assign tick = (MODE_IN == MODE_FAST) || lf_q4;
            assign need = (MODE_IN == MODE_FAST) ? NEED_FIXED : NEED_SLOW;
            assign hit = filt_prev[ch] && !filt[ch];
        end else begin : g_prog
            logic [3:0] mask;
            assign mask = rate_mask(rate_sel[ch]);
            assign tick = ((MODE_IN == MODE_FAST) && ((pre & mask) == mask)) || lf_q4;
            assign need = (MODE_IN == MODE_FAST) ? NEED_FAST_PROG : NEED_SLOW;

            always_comb begin
                hit = 1'b0;
                case (trig_sel[ch])
                    TRIG_RISE: hit = !filt_prev[ch] && filt[ch];
                    TRIG_FALL: hit = filt_prev[ch] && !filt[ch];
                    TRIG_BOTH: hit = filt_prev[ch] != filt[ch];
                    // Reserved on 1-3; level mode repeats once per sample
                    TRIG_HIGH: hit = (ch == 4) && filt[ch] && tick;
                    default: hit = 1'b0;
                endcase
            end

            always_ff @(posedge CLK_IN) begin
                if (SRST_IN) begin
                    trig_sel[ch] <= CTRL_FIELD_RESET;
                    rate_sel[ch] <= CTRL_FIELD_RESET;
                end else if (WR_IN && ADDR_IN == CTRL1_ADDR + 12'(ch - 1)) begin
                    trig_sel[ch] <= WDATA_IN[TRIG_LSB +: 2];
                    rate_sel[ch] <= WDATA_IN[RATE_LSB +: 2];
                end
            end

            always_ff @(posedge CLK_IN) begin
                if (SRST_IN) begin
                    lvl[ch] <= LVL_RESET;
                end else if (next_req[ch]) begin
                    lvl[ch] <= filt[ch];
                end
            end
        end

        pin_irq_filter u_filter (
            .clk_in(CLK_IN),
            .srst_in(SRST_IN),
            .run_in(gate[ch]),
            .tick_in(tick && MODE_IN != MODE_HALT),
            .need_in(need),
            .sample_in(pin_s[ch]),
            .level_out(filt[ch])
        );

        assign next_req[ch] = hit && gate[ch] && (MODE_IN != MODE_HALT);
    end

    // ************************************************************
    // Request pulses
    // ************************************************************
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            filt_prev <= 6'h00;
            IRQ_REQ_OUT <= 6'h00;
        end else begin
            filt_prev <= filt;
            IRQ_REQ_OUT <= next_req;
        end
    end

    // ************************************************************
    // Register port
    // ************************************************************
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            gate <= GATE_RESET;
        end else if (WR_IN && ADDR_IN == GATE_ADDR) begin
            gate <= WDATA_IN[CHANNELS-1:0];
        end
    end

    always_comb begin
        next_rdata = READ_IDLE;
        case (ADDR_IN)
            GATE_ADDR: next_rdata = {2'h0, gate};
            CTRL1_ADDR: next_rdata = {3'h0, lvl[1], trig_sel[1], rate_sel[1]};
            CTRL2_ADDR: next_rdata = {3'h0, lvl[2], trig_sel[2], rate_sel[2]};
            CTRL3_ADDR: next_rdata = {3'h0, lvl[3], trig_sel[3], rate_sel[3]};
            CTRL4_ADDR: next_rdata = {3'h0, lvl[4], trig_sel[4], rate_sel[4]};
            default: next_rdata = READ_IDLE;
        endcase
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            RDATA_OUT <= READ_IDLE;
        end else begin
            RDATA_OUT <= RD_IN ? next_rdata : READ_IDLE;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    logic [2:0] fast1_run;

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            fast1_run <= 3'h0;
        end else if (MODE_IN == MODE_FAST && gate[1] && rate_sel[1] == RATE_DIV1) begin
            if (fast1_run != 3'h7) begin
                fast1_run <= fast1_run + 3'h1;
            end
        end else begin
            fast1_run <= 3'h0;
        end
    end

    AST_GATE_RESET: assert property (@(posedge CLK_IN) $past(SRST_IN) |-> gate == 6'h00)
        else $error("gate bits not cleared by reset");

    AST_GATE_OFF_QUIET: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        (IRQ_REQ_OUT & ~$past(gate)) == 6'h00)
        else $error("request from a gated channel");

    AST_HALT_QUIET: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        $past(MODE_IN) == MODE_HALT |-> IRQ_REQ_OUT == 6'h00)
        else $error("request while sampling halted");

    AST_CH0_FALL: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        IRQ_REQ_OUT[0] |-> $past(filt_prev[0]) && !$past(filt[0]))
        else $error("channel 0 request without falling edge");

    AST_CH0_ACCEPT: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        (MODE_IN == MODE_FAST && gate[0] && pin_s[0] && !filt[0])
        ##1 (MODE_IN == MODE_FAST && gate[0] && pin_s[0]) |=> filt[0])
        else $error("channel 0 missed a two-cycle pulse");

    AST_PROG_THREE: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        ($changed(filt[1]) && fast1_run >= 3'h4 && gate[1])
        |-> $past(pin_s[1], 1) == filt[1] && $past(pin_s[1], 2) == filt[1] && $past(pin_s[1], 3) == filt[1])
        else $error("channel 1 accepted fewer than three samples");

    AST_RESERVED_CODE: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        $past(trig_sel[1]) == TRIG_HIGH |-> !IRQ_REQ_OUT[1])
        else $error("reserved trigger code raised a request");

    AST_LVL_CAPTURE: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        IRQ_REQ_OUT[4] |-> lvl[4] == $past(filt[4]))
        else $error("level bit not reloaded on request");

    AST_PULSE: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        IRQ_REQ_OUT[0] |=> !IRQ_REQ_OUT[0])
        else $error("channel 0 request longer than one cycle");

    AST_CTRL4_READ: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        $past(RD_IN && ADDR_IN == CTRL4_ADDR)
        |-> RDATA_OUT == {3'h0, $past(lvl[4]), $past(trig_sel[4]), $past(rate_sel[4])})
        else $error("channel 4 control read wrong");

    COV_CH0_REQ: cover property (@(posedge CLK_IN) disable iff (SRST_IN) IRQ_REQ_OUT[0]);
    COV_CH4_BOTH: cover property (@(posedge CLK_IN) disable iff (SRST_IN)
        IRQ_REQ_OUT[4] && trig_sel[4] == TRIG_BOTH && !lvl[4]);
    COV_SLOW_REQ: cover property (@(posedge CLK_IN) disable iff (SRST_IN)
        IRQ_REQ_OUT[1] && MODE_IN == MODE_SLOW);

endmodule

/* File: rtl/pin_irq_pkg.sv */
// Constants, register map and types for the pin interrupt front end
package pin_irq_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int CHANNELS = 6;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [11:0] GATE_ADDR = 12'hFD0;
    localparam logic [11:0] CTRL1_ADDR = 12'hFD8;
    localparam logic [11:0] CTRL2_ADDR = 12'hFD9;
    localparam logic [11:0] CTRL3_ADDR = 12'hFDA;
    localparam logic [11:0] CTRL4_ADDR = 12'hFDB;

    // Control register fields
    localparam int RATE_LSB = 0;
    localparam int TRIG_LSB = 2;
    localparam int LVL_BIT = 4;
    localparam logic [1:0] CTRL_FIELD_RESET = 2'h0;
    localparam logic LVL_RESET = 1'b0;
    localparam logic [5:0] GATE_RESET = 6'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // Trigger select codes
    localparam logic [1:0] TRIG_RISE = 2'h0;
    localparam logic [1:0] TRIG_FALL = 2'h1;
    localparam logic [1:0] TRIG_BOTH = 2'h2;
    localparam logic [1:0] TRIG_HIGH = 2'h3;

    // Filter rate codes
    localparam logic [1:0] RATE_DIV1 = 2'h0;
    localparam logic [1:0] RATE_DIV4 = 2'h1;
    localparam logic [1:0] RATE_DIV8 = 2'h2;
    localparam logic [1:0] RATE_DIV16 = 2'h3;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 25;
    // Fixed channels accept a level held for two gear periods
    localparam int FIX_ACCEPT_NS = 50;
    localparam logic [1:0] NEED_FIXED = 2'(FIX_ACCEPT_NS / CLK_PERIOD_NS);
    localparam logic [1:0] NEED_FAST_PROG = 2'h3;
    localparam logic [1:0] NEED_SLOW = 2'h2;
    localparam logic [1:0] LF_DIV_LAST = 2'h3;
    localparam logic [3:0] PRE_RESET = 4'h0;
    localparam logic [1:0] LF_DIV_RESET = 2'h0;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {MODE_FAST, MODE_SLOW, MODE_HALT} mode_t;

    // Prescaler bits that must be all ones for a sample in fast mode
    function automatic logic [3:0] rate_mask(input logic [1:0] code);
        logic [3:0] m;
        m = 4'h0;
        case (code)
            RATE_DIV1: m = 4'h0;
            RATE_DIV4: m = 4'h3;
            RATE_DIV8: m = 4'h7;
            RATE_DIV16: m = 4'hF;
            default: m = 4'h0;
        endcase
        return m;
    endfunction

endpackage
